// >>> core/extender_self_test.sv
`timescale 1ns/1ps
module extender_self_test import st_pkg::*; #(
	parameter int unsigned PF_DELAY_CYC_P    = PF_DELAY_CYC,
	parameter int unsigned FIBER_FLASH_CYC_P = FIBER_FLASH_CYC,
	parameter int unsigned COAX_FLASH_CYC_P  = COAX_FLASH_CYC
) (
	// Clock and power-on reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	// Panel straps
	input  wire logic                 test_sw_i,
	input  wire logic                 fiber_a_i,
	input  wire logic                 fiber_b_i,
	input  wire logic                 slow_i,
	input  wire logic                 pf_ext_i,
	// Link ports
	output logic                      port_a_tx_o,
	output logic                      port_b_tx_o,
	input  wire logic                 port_a_rx_i,
	input  wire logic                 port_b_rx_i,
	// Bus lines, open drain
	input  wire logic [BUS_LINES-1:0] bus_i,
	output logic [BUS_LINES-1:0]      bus_o,
	output logic [BUS_LINES-1:0]      bus_oe_b_o,
	// Lamps
	output logic                      fault_a_o,
	output logic                      fault_b_o,
	// Register port
	input  wire logic [ADDR_W-1:0]    reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_we_i,
	input  wire logic                 reg_re_i,
	output logic [31:0]               reg_rdata_o,
	// Interrupt
	output logic                      irq_o
);
	st_state_t            state_q, state_d;
	straps_t              straps_q, straps_d;
	logic [CNT_W-1:0]     tmr_q, tmr_d, flash_len, slot_len, slot_q, slot_d;
	logic [7:0]           bit_cyc;
	logic                 pass_ev;
	port_t                tgt_q, tgt_d;
	logic [DATA_BITS-1:0] word_q, word_d;
	logic [BUS_LINES-1:0] drv_q, drv_d;
	logic                 rot_q, rot_d, ok_q, ok_d, bad_q, bad_d;
	logic                 cur_a_q, cur_a_d, cur_b_q, cur_b_d;
	logic                 lat_a_q, lat_a_d, lat_b_q, lat_b_d, bus_lat_q, bus_lat_d;
	logic                 tx_start, tx_ser, tx_busy, slot_end, pass;
	logic                 ev_a, ev_b, ev_bus;
	logic [DATA_BITS-1:0] rxa_word, rxb_word;
	logic                 rxa_val, rxb_val, rxa_ok, rxb_ok;
	logic                 lamp_a_q, lamp_a_d, lamp_b_q, lamp_b_d, pa_q, pa_d, pb_q, pb_d;
	logic [EV_W-1:0]      status_q, status_d, mask_q, mask_d, events;
	logic [31:0]          rdata_q, rdata_d;

	assign flash_len = (straps_q.fiber_a || straps_q.fiber_b) ? CNT_W'(FIBER_FLASH_CYC_P)
		: CNT_W'(COAX_FLASH_CYC_P);
	// frame and slot length by speed
	assign bit_cyc  = straps_q.slow ? 8'(BIT_SLOW_CYC) : 8'(BIT_NORM_CYC);
	assign slot_len = straps_q.slow ? CNT_W'(SLOT_SLOW_CYC) : CNT_W'(SLOT_NORM_CYC);
	assign slot_end = (state_q == ST_RUN) && (slot_q == slot_len - CNT_W'(1));
	assign tx_start = (state_q == ST_RUN) && (slot_q == '0);

	// Power-on sequence
	always_comb begin
		state_d  = state_q;
		tmr_d    = tmr_q;
		straps_d = straps_q;
		pass_ev  = 1'b0;
		case (state_q)
			ST_CAPTURE: begin
				straps_d = {test_sw_i, fiber_a_i, fiber_b_i, slow_i, pf_ext_i};
				tmr_d    = '0;
				if (!test_sw_i) state_d = ST_OFF;
				else if (pf_ext_i) state_d = ST_DELAY;
				else state_d = ST_FLASH;
			end
			ST_DELAY: begin
				if (tmr_q == CNT_W'(PF_DELAY_CYC_P) - CNT_W'(1)) begin
					tmr_d   = '0;
					state_d = ST_FLASH;
				end else begin
					tmr_d = tmr_q + CNT_W'(1);
				end
			end
			ST_FLASH: begin
				if (tmr_q == flash_len - CNT_W'(1)) begin
					tmr_d   = '0;
					state_d = ST_RUN;
					pass_ev = 1'b1;
				end else begin
					tmr_d = tmr_q + CNT_W'(1);
				end
			end
			ST_OFF, ST_RUN: state_d = state_q;
			default: state_d = ST_CAPTURE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q  <= ST_CAPTURE;
			tmr_q    <= '0;
			straps_q <= '0;
		end else begin
			state_q  <= state_d;
			tmr_q    <= tmr_d;
			straps_q <= straps_d;
		end
	end

	frame_tx u_tx (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.start_i   (tx_start),
		.word_i    (word_q),
		.bit_cyc_i (bit_cyc),
		.ser_o     (tx_ser),
		.busy_o    (tx_busy)
	);

	frame_rx u_rx_a (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.ser_i     (port_a_rx_i),
		.bit_cyc_i (bit_cyc),
		.word_o    (rxa_word),
		.stop_ok_o (rxa_ok),
		.valid_o   (rxa_val)
	);

	frame_rx u_rx_b (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.ser_i     (port_b_rx_i),
		.bit_cyc_i (bit_cyc),
		.word_o    (rxb_word),
		.stop_ok_o (rxb_ok),
		.valid_o   (rxb_val)
	);

	// Slot scheduling and checking
	always_comb begin
		slot_d    = slot_q;
		tgt_d     = tgt_q;
		word_d    = word_q;
		rot_d     = rot_q;
		ok_d      = ok_q;
		bad_d     = bad_q;
		cur_a_d   = cur_a_q;
		cur_b_d   = cur_b_q;
		lat_a_d   = lat_a_q;
		lat_b_d   = lat_b_q;
		bus_lat_d = bus_lat_q;
		ev_a      = 1'b0;
		ev_b      = 1'b0;
		ev_bus    = 1'b0;
		pass      = ok_q && !bad_q;
		if (state_q == ST_RUN) begin
			slot_d = slot_end ? '0 : slot_q + CNT_W'(1);
			if (tx_start) begin
				ok_d  = 1'b0;
				bad_d = 1'b0;
				if (cur_a_q && !cur_b_q) tgt_d = PORT_A;
				else if (cur_b_q && !cur_a_q) tgt_d = PORT_B;
				else tgt_d = (tgt_q == PORT_A) ? PORT_B : PORT_A;
			end
			if (rxa_val && tgt_q == PORT_A) begin
				if (rxa_ok && rxa_word == word_q) ok_d = 1'b1;
				else bad_d = 1'b1;
			end
			if (rxb_val && tgt_q == PORT_B) begin
				if (rxb_ok && rxb_word == word_q) ok_d = 1'b1;
				else bad_d = 1'b1;
			end
			if (slot_end) begin
				if (tgt_q == PORT_A) begin
					cur_a_d = !pass;
					if (!pass) begin
						lat_a_d = 1'b1;
						ev_a    = !lat_a_q;
					end
				end else begin
					cur_b_d = !pass;
					if (!pass) begin
						lat_b_d = 1'b1;
						ev_b    = !lat_b_q;
					end
				end
				if (bus_i != drv_q) begin
					bus_lat_d = 1'b1;
					ev_bus    = !bus_lat_q;
				end
				word_d = rot_q ? {~word_q[DATA_BITS-2:0], ~word_q[DATA_BITS-1]} : ~word_q;
				rot_d  = !rot_q;
			end
		end
		drv_d = (state_d == ST_RUN) ? word_d : '1;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			slot_q    <= '0;
			tgt_q     <= PORT_B;
			word_q    <= WORD_RST;
			rot_q     <= 1'b0;
			ok_q      <= 1'b0;
			bad_q     <= 1'b0;
			cur_a_q   <= 1'b0;
			cur_b_q   <= 1'b0;
			lat_a_q   <= 1'b0;
			lat_b_q   <= 1'b0;
			bus_lat_q <= 1'b0;
			drv_q     <= '1;
		end else begin
			slot_q    <= slot_d;
			tgt_q     <= tgt_d;
			word_q    <= word_d;
			rot_q     <= rot_d;
			ok_q      <= ok_d;
			bad_q     <= bad_d;
			cur_a_q   <= cur_a_d;
			cur_b_q   <= cur_b_d;
			lat_a_q   <= lat_a_d;
			lat_b_q   <= lat_b_d;
			bus_lat_q <= bus_lat_d;
			drv_q     <= drv_d;
		end
	end

	// Lamps and port steering
	always_comb begin
		lamp_a_d = (state_d == ST_FLASH) || lat_a_d || bus_lat_d;
		lamp_b_d = (state_d == ST_FLASH) || lat_b_d || bus_lat_d;
		pa_d     = tx_ser && (tgt_q == PORT_A);
		pb_d     = tx_ser && (tgt_q == PORT_B);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			lamp_a_q <= 1'b0;
			lamp_b_q <= 1'b0;
			pa_q     <= 1'b0;
			pb_q     <= 1'b0;
		end else begin
			lamp_a_q <= lamp_a_d;
			lamp_b_q <= lamp_b_d;
			pa_q     <= pa_d;
			pb_q     <= pb_d;
		end
	end

	// Registers; a new event wins over a clear
	always_comb begin
		events                = '0;
		events[EV_FAIL_A]     = ev_a;
		events[EV_FAIL_B]     = ev_b;
		events[EV_BUS]        = ev_bus;
		events[EV_PASS]       = pass_ev;
		status_d              = status_q;
		mask_d                = mask_q;
		rdata_d               = '0;
		if (reg_we_i && reg_addr_i == REG_STATUS) status_d = status_q & ~reg_wdata_i[EV_W-1:0];
		else if (reg_we_i && reg_addr_i == REG_MASK) mask_d = reg_wdata_i[EV_W-1:0];
		status_d = status_d | events;
		if (reg_re_i) begin
			if (reg_addr_i == REG_STATUS) rdata_d = 32'(status_q);
			else if (reg_addr_i == REG_MASK) rdata_d = 32'(mask_q);
			else if (reg_addr_i == REG_STATE)
				rdata_d = 32'({tgt_q, cur_b_q, cur_a_q, lamp_b_q, lamp_a_q, state_q, straps_q});
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			status_q <= '0;
			mask_q   <= MASK_RST;
			rdata_q  <= '0;
		end else begin
			status_q <= status_d;
			mask_q   <= mask_d;
			rdata_q  <= rdata_d;
		end
	end

	assign port_a_tx_o = pa_q;
	assign port_b_tx_o = pb_q;
	assign bus_o       = '0;
	assign bus_oe_b_o  = drv_q;
	assign fault_a_o   = lamp_a_q;
	assign fault_b_o   = lamp_b_q;
	assign reg_rdata_o = rdata_q;
	assign irq_o       = |(status_q & mask_q);

	// Checking helpers
	logic [CNT_W-1:0] dwell_q, gap_q, busy_n_q;
	logic             seen_q;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dwell_q  <= '0;
			gap_q    <= '0;
			busy_n_q <= '0;
			seen_q   <= 1'b0;
		end else begin
			dwell_q  <= (state_d == state_q) ? dwell_q + CNT_W'(1) : '0;
			gap_q    <= tx_start ? '0 : gap_q + CNT_W'(1);
			busy_n_q <= tx_start ? '0 : busy_n_q + CNT_W'(tx_busy);
			seen_q   <= seen_q || tx_start;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_alt_ports: assert property (tx_start && !cur_a_q && !cur_b_q |=> tgt_q != $past(tgt_q))
		else $error("ports not alternated");
	a_no_return: assert property (slot_end && tgt_q == PORT_A && !ok_q |=> cur_a_q && lat_a_q)
		else $error("missing frame not failed");
	a_fail_port_only: assert property (state_q == ST_RUN && cur_a_q && !cur_b_q && slot_q > CNT_W'(1)
		|-> !port_b_tx_o && tgt_q == PORT_A)
		else $error("frame sent to passing port");
	a_slot_gap: assert property (tx_start && seen_q |-> gap_q == slot_len - CNT_W'(1))
		else $error("frame repetition wrong");
	a_frame_len: assert property (tx_start && seen_q
		|-> busy_n_q + CNT_W'(tx_busy) == CNT_W'(bit_cyc) * CNT_W'(FRAME_BITS))
		else $error("frame length wrong");
	a_flash_lamps: assert property (state_q inside {ST_DELAY, ST_FLASH}
		|-> (lamp_a_q && lamp_b_q) == (state_q == ST_FLASH))
		else $error("flash lamps dark");
	a_run_dark: assert property (state_q == ST_RUN && !lat_a_q && !bus_lat_q |-> !fault_a_o)
		else $error("lamp lit without failure");
	a_latch_hold: assert property (lat_a_q |=> lat_a_q && fault_a_o)
		else $error("failure latch lost");
	a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
		!rst_b_i |=> !lat_a_q && !lat_b_q && state_q == ST_CAPTURE)
		else $error("reset did not clear");
	a_bus_fault: assert property (slot_end && bus_i != drv_q |=> bus_lat_q && fault_a_o && fault_b_o)
		else $error("bus line fault missed");
	a_flash_len: assert property ($fell(state_q == ST_FLASH) |-> $past(dwell_q) == flash_len - CNT_W'(1))
		else $error("flash length wrong");
	a_pf_delay: assert property ($fell(state_q == ST_DELAY)
		|-> straps_q.pf_ext && $past(dwell_q) == CNT_W'(PF_DELAY_CYC_P) - CNT_W'(1))
		else $error("power-fail delay wrong");

	c_pass_run: cover property ($rose(state_q == ST_RUN));
	c_fail_a: cover property ($rose(lat_a_q));
	c_recover_a: cover property ($fell(cur_a_q));
	c_bus_fail: cover property ($rose(bus_lat_q));
endmodule // extender_self_test

// >>> pkg/st_pkg.sv
package st_pkg;

	// Clock and widths
	localparam real CLK_HZ    = 200.0e6;
	localparam int  FRAME_BITS = 20;
	localparam int  DATA_BITS  = 16;
	localparam int  BUS_LINES  = 16;
	localparam int  CNT_W      = 32;

	// Frame timing, normal and slow link speed
	localparam real FRAME_NORM_US = 2.0;
	localparam real FRAME_SLOW_US = 20.0;
	localparam real REPEAT_US     = 15.0;
	localparam int  FRAME_NORM_CYC = int'(FRAME_NORM_US * CLK_HZ / 1.0e6);
	localparam int  FRAME_SLOW_CYC = int'(FRAME_SLOW_US * CLK_HZ / 1.0e6);
	localparam int  REPEAT_CYC     = int'(REPEAT_US * CLK_HZ / 1.0e6);
	localparam int  BIT_NORM_CYC   = FRAME_NORM_CYC / FRAME_BITS;
	localparam int  BIT_SLOW_CYC   = FRAME_SLOW_CYC / FRAME_BITS;
	localparam int  SLOT_NORM_CYC  = (FRAME_NORM_CYC > REPEAT_CYC) ? FRAME_NORM_CYC : REPEAT_CYC;
	localparam int  SLOT_SLOW_CYC  = (FRAME_SLOW_CYC > REPEAT_CYC) ? FRAME_SLOW_CYC : REPEAT_CYC;

	// Power-on lamp timing
	localparam real PF_DELAY_S      = 1.5;
	localparam real FIBER_FLASH_S   = 2.6;
	localparam real COAX_FLASH_MS   = 300.0;
	localparam int  PF_DELAY_CYC    = int'(PF_DELAY_S * CLK_HZ);
	localparam int  FIBER_FLASH_CYC = int'(FIBER_FLASH_S * CLK_HZ);
	localparam int  COAX_FLASH_CYC  = int'(COAX_FLASH_MS * CLK_HZ / 1.0e3);

	// Register port
	localparam int         ADDR_W     = 4;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK   = 4'h4;
	localparam logic [3:0] REG_STATE  = 4'h8;

	// Event bits in status and mask
	localparam int EV_FAIL_A = 0;
	localparam int EV_FAIL_B = 1;
	localparam int EV_BUS    = 2;
	localparam int EV_PASS   = 3;
	localparam int EV_W      = 4;

	// Values after reset
	localparam logic [EV_W-1:0]      MASK_RST = 4'h0;
	localparam logic [DATA_BITS-1:0] WORD_RST = 16'h00ff;

	typedef struct packed {
		logic test;
		logic fiber_a;
		logic fiber_b;
		logic slow;
		logic pf_ext;
	} straps_t;

	typedef enum logic [2:0] {ST_CAPTURE, ST_OFF, ST_DELAY, ST_FLASH, ST_RUN} st_state_t;

	typedef enum logic {PORT_A, PORT_B} port_t;

endpackage

// >>> core/frame_tx.sv
`timescale 1ns/1ps
module frame_tx import st_pkg::*; (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	// Request
	input  wire logic                 start_i,
	input  wire logic [DATA_BITS-1:0] word_i,
	input  wire logic [7:0]           bit_cyc_i,
	// Serial out
	output logic                      ser_o,
	output logic                      busy_o
);
	logic [FRAME_BITS-1:0] sh_q, sh_d;
	logic [7:0]            bc_q, bc_d;
	logic [4:0]            n_q, n_d;
	logic                  busy_q, busy_d, ser_q, ser_d, last_bit;

	// Next frame may follow the last stop bit directly
	assign last_bit = busy_q && (bc_q == bit_cyc_i - 8'h01) && (n_q == 5'(FRAME_BITS - 1));

	// Start bit, data bits, then idle stop bits
	always_comb begin
		sh_d   = sh_q;
		bc_d   = bc_q;
		n_d    = n_q;
		busy_d = busy_q;
		if (start_i && (!busy_q || last_bit)) begin
			sh_d   = {3'h0, word_i, 1'b1};
			bc_d   = 8'h00;
			n_d    = 5'h00;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (bc_q == bit_cyc_i - 8'h01) begin
				bc_d = 8'h00;
				sh_d = sh_q >> 1;
				if (n_q == 5'(FRAME_BITS - 1)) busy_d = 1'b0;
				else n_d = n_q + 5'h01;
			end else begin
				bc_d = bc_q + 8'h01;
			end
		end
		ser_d = busy_d & sh_d[0];
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sh_q   <= '0;
			bc_q   <= 8'h00;
			n_q    <= 5'h00;
			busy_q <= 1'b0;
			ser_q  <= 1'b0;
		end else begin
			sh_q   <= sh_d;
			bc_q   <= bc_d;
			n_q    <= n_d;
			busy_q <= busy_d;
			ser_q  <= ser_d;
		end
	end

	assign ser_o  = ser_q;
	assign busy_o = busy_q;
endmodule // frame_tx

// >>> core/frame_rx.sv
`timescale 1ns/1ps
module frame_rx import st_pkg::*; (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	// Serial in
	input  wire logic                 ser_i,
	input  wire logic [7:0]           bit_cyc_i,
	// Received frame
	output logic [DATA_BITS-1:0]      word_o,
	output logic                      stop_ok_o,
	output logic                      valid_o
);
	logic [DATA_BITS-1:0] sh_q, sh_d;
	logic [7:0]           bc_q, bc_d, tgt;
	logic [4:0]           n_q, n_d;
	logic                 act_q, act_d, val_q, val_d, ok_q, ok_d;

	// Samples each bit at its centre
	always_comb begin
		sh_d  = sh_q;
		bc_d  = bc_q;
		n_d   = n_q;
		act_d = act_q;
		ok_d  = ok_q;
		val_d = 1'b0;
		tgt   = (n_q == 5'h00) ? {1'b0, bit_cyc_i[7:1]} : bit_cyc_i;
		if (!act_q) begin
			if (ser_i) begin
				act_d = 1'b1;
				bc_d  = 8'h00;
				n_d   = 5'h00;
			end
		end else if (bc_q == tgt - 8'h01) begin
			bc_d = 8'h00;
			n_d  = n_q + 5'h01;
			if (n_q == 5'h00) begin
				act_d = ser_i;
			end else if (n_q <= 5'(DATA_BITS)) begin
				sh_d = {ser_i, sh_q[DATA_BITS-1:1]};
			end else begin
				val_d = 1'b1;
				ok_d  = !ser_i;
				act_d = 1'b0;
			end
		end else begin
			bc_d = bc_q + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sh_q  <= '0;
			bc_q  <= 8'h00;
			n_q   <= 5'h00;
			act_q <= 1'b0;
			val_q <= 1'b0;
			ok_q  <= 1'b0;
		end else begin
			sh_q  <= sh_d;
			bc_q  <= bc_d;
			n_q   <= n_d;
			act_q <= act_d;
			val_q <= val_d;
			ok_q  <= ok_d;
		end
	end

	assign word_o    = sh_q;
	assign stop_ok_o = ok_q;
	assign valid_o   = val_q;
endmodule // frame_rx

// >>> testbench/loopback_model.sv
`timescale 1ns/1ps
module loopback_model import st_pkg::*; (
	// Clock
	input  wire logic                 clk_i,
	// Link loop-backs, bit 0 port A
	input  wire logic [1:0]           tx_i,
	input  wire logic [1:0]           drop_i,
	input  wire logic [1:0]           flip_i,
	output logic      [1:0]           rx_o,
	// Bus transceiver loop-back
	input  wire logic [BUS_LINES-1:0] oe_b_i,
	input  wire logic [BUS_LINES-1:0] stuck_i,
	output logic [BUS_LINES-1:0]      bus_o
);
	logic [1:0]  tx_q;
	logic [15:0] cnt_q [2];

	always_ff @(posedge clk_i) begin
		tx_q <= tx_i;
		for (int i = 0; i < 2; i++) begin
			cnt_q[i] <= (tx_i[i] && !tx_q[i]) ? 16'h0001 : cnt_q[i] + 16'h0001;
		end
	end

	// Open loop idles low; flip inverts the line 60 to 79 cycles after each rising edge
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rx_o[i] = !drop_i[i] && (tx_i[i] ^ (flip_i[i] && cnt_q[i] >= 16'h003c && cnt_q[i] < 16'h0050));
		end
	end

	// Released lines pulled high, stuck lines read low
	assign bus_o = oe_b_i & ~stuck_i;
endmodule // loopback_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp=%0h got=%0h", nm, e, g); end end
module tb_top import st_pkg::*;;
	localparam int PF_P = 50;
	localparam int FL_P = 80;
	localparam int CX_P = 30;

	logic                 clk_i;
	logic                 rst_b_i;
	straps_t              st;
	logic                 port_a_tx_o;
	logic                 port_b_tx_o;
	logic [1:0]           rx;
	logic [1:0]           drop;
	logic [1:0]           flip;
	logic [BUS_LINES-1:0] stuck;
	logic [BUS_LINES-1:0] bus_i;
	logic [BUS_LINES-1:0] bus_oe_b_o;
	logic [BUS_LINES-1:0] seen0;
	logic [BUS_LINES-1:0] seen1;
	logic                 fault_a_o;
	logic                 fault_b_o;
	logic [ADDR_W-1:0]    reg_addr_i;
	logic [31:0]          reg_wdata_i;
	logic                 reg_we_i;
	logic                 reg_re_i;
	logic [31:0]          reg_rdata_o;
	logic                 irq_o;
	int                   mismatches = 0;
	int                   comparisons = 0;
	int                   cyc = 0;
	int                   last_start;

	extender_self_test #(
		.PF_DELAY_CYC_P   (PF_P),
		.FIBER_FLASH_CYC_P(FL_P),
		.COAX_FLASH_CYC_P (CX_P)
	) u_extender_self_test (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .test_sw_i(st.test), .fiber_a_i(st.fiber_a),
		.fiber_b_i(st.fiber_b), .slow_i(st.slow), .pf_ext_i(st.pf_ext),
		.port_a_tx_o(port_a_tx_o), .port_b_tx_o(port_b_tx_o), .port_a_rx_i(rx[0]), .port_b_rx_i(rx[1]),
		.bus_i(bus_i), .bus_o(), .bus_oe_b_o(bus_oe_b_o), .fault_a_o(fault_a_o), .fault_b_o(fault_b_o),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
	);

	loopback_model u_loopback_model (
		.clk_i(clk_i), .tx_i({port_b_tx_o, port_a_tx_o}), .drop_i(drop), .flip_i(flip), .rx_o(rx),
		.oe_b_i(bus_oe_b_o), .stuck_i(stuck), .bus_o(bus_i)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) cyc <= cyc + 1;

	task automatic tally_and_finish;
		$display("TB: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_we_i    <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		#1;
	endtask

	// Start bit, data LSB first, stop bits
	function automatic logic frame_bit(input logic [DATA_BITS-1:0] w, input int k);
		if (k == 0) return 1'b1;
		if (k <= DATA_BITS) return w[k-1];
		return 1'b0;
	endfunction

	task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// straps set while power is off
	task automatic power_cycle(input straps_t s, input logic [BUS_LINES-1:0] stk);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		st      <= s;
		stuck   <= stk;
		drop    <= 2'b00;
		flip    <= 2'b00;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		last_start = 0;
	endtask

	task automatic flash_check(input int dly, input int len);
		int n;
		int m;
		n = 0;
		m = 0;
		while (fault_a_o !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			#1 n++;
		end
		`CHK("flash_at", 1'b1, n >= dly + 1 && n <= dly + 3) // start of flash
		`CHK("flash_both", 2'b11, {fault_a_o, fault_b_o}) // both lamps
		while (fault_a_o === 1'b1 && m < 2000) begin
			@(posedge clk_i);
			#1 m++;
		end
		`CHK("flash_len", 1'b1, m >= len - 1 && m <= len + 1) // flash length
	endtask

	task automatic next_frame(input int bt, input int slot, output logic p);
		logic [DATA_BITS-1:0] w;
		logic                 e;
		int                   n;
		n = 0;
		while (port_a_tx_o !== 1'b1 && port_b_tx_o !== 1'b1 && n < 5000) begin
			@(posedge clk_i);
			#1 n++;
		end
		`CHK("frame_seen", 1'b1, n < 5000) // frames keep coming
		if (last_start != 0) `CHK("slot", slot, cyc - last_start) // repetition
		last_start = cyc;
		p = port_b_tx_o;
		w = bus_oe_b_o;
		seen1 |= w;
		seen0 |= ~w;
		repeat (bt / 2) @(posedge clk_i);
		for (int k = 0; k < FRAME_BITS; k++) begin
			#1 e = frame_bit(w, k);
			`CHK("frame_bit", {e, 1'b0}, p ? {port_b_tx_o, port_a_tx_o} : {port_a_tx_o, port_b_tx_o})
			if (k < FRAME_BITS - 1) repeat (bt) @(posedge clk_i);
		end
	endtask

	initial begin
		logic [31:0] rd;
		logic [3:0]  r;
		logic [4:0]  act;
		logic        p;
		logic        mode;
		rst_b_i = 1'b0;
		st = '0;
		drop = 2'b00;
		flip = 2'b00;
		stuck = '0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		seen0 = '0;
		seen1 = '0;
		void'($urandom(13545));
		// Coax pass run, normal speed
		power_cycle(straps_t'(5'b10000), '0);
		flash_check(0, CX_P);
		@(posedge clk_i);
		st.test <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			next_frame(BIT_NORM_CYC, SLOT_NORM_CYC, p);
			`CHK("target", k[0], p) // alternation
		end
		`CHK("lamps_dark", 2'b00, {fault_a_o, fault_b_o}) // dark after flash
		`CHK("lines", {2{16'hffff}}, {seen0, seen1}) // lines both levels
		reg_rd(REG_STATUS, rd);
		`CHK("status", 32'h0000_0008, rd) // pass event
		reg_rd(REG_STATE, rd);
		`CHK("state", 12'h090, rd[11:0]) // straps sampled once
		reg_rd(4'hc, rd);
		`CHK("unmapped", 32'h0000_0000, rd)
		r = 4'($urandom_range(15));
		reg_wr(REG_MASK, {28'h0, r});
		reg_wr(4'hc, 32'hffff_ffff);
		reg_rd(REG_MASK, rd);
		`CHK("mask", {28'h0, r}, rd)
		`CHK("irq", r[EV_PASS], irq_o)
		reg_wr(REG_STATUS, 32'h0000_0008);
		reg_rd(REG_STATUS, rd);
		`CHK("w1c", 32'h0000_0000, rd)
		`CHK("irq_clr", 1'b0, irq_o)
		// one fiber port selected, slow speed, power-fail delay
		power_cycle(straps_t'(5'b10011 | ($urandom_range(1) ? 5'b01000 : 5'b00100)), '0);
		flash_check(PF_P, FL_P);
		for (int k = 0; k < 3; k++) begin
			next_frame(BIT_SLOW_CYC, SLOT_SLOW_CYC, p);
			`CHK("target_slow", k[0], p) // slow alternation
		end
		// Lost or damaged frame on each port
		for (int i = 0; i < 2; i++) begin
			mode = 1'($urandom_range(1));
			power_cycle(straps_t'(5'b10000), '0);
			drop[i] <= !mode;
			flip[i] <= mode;
			flash_check(0, CX_P);
			for (int k = 0; k < 3 + i; k++) begin
				next_frame(BIT_NORM_CYC, SLOT_NORM_CYC, p);
				`CHK("retry", (k < i) ? 1'b0 : i[0], p) // only failing port
			end
			reg_wr(REG_MASK, 32'h1 << i);
			`CHK("lamp_fail", 2'b10 >> i, {fault_a_o, fault_b_o}) // matching lamp
			`CHK("irq_fail", 1'b1, irq_o) // fail event
			reg_rd(REG_STATUS, rd);
			`CHK("status_fail", 3'b001 << i, rd[2:0]) // latched port
			@(posedge clk_i);
			drop <= 2'b00;
			flip <= 2'b00;
			reg_wr(REG_STATUS, 32'h1 << i);
			`CHK("irq_w1c", 1'b0, irq_o)
			next_frame(BIT_NORM_CYC, SLOT_NORM_CYC, p);
			`CHK("good_frame", i[0], p) // until good frame
			next_frame(BIT_NORM_CYC, SLOT_NORM_CYC, p);
			`CHK("resume", !i[0], p) // alternation resumes
			`CHK("lamp_held", 2'b10 >> i, {fault_a_o, fault_b_o}) // lamp stays lit
		end
		// Stuck bus line
		power_cycle(straps_t'(5'b10000), 16'h0001 << $urandom_range(15));
		flash_check(0, CX_P);
		repeat (3) next_frame(BIT_NORM_CYC, SLOT_NORM_CYC, p);
		`CHK("lamp_bus", 2'b11, {fault_a_o, fault_b_o}) // line fault
		reg_rd(REG_STATUS, rd);
		`CHK("status_bus", 1'b1, rd[EV_BUS]) // line fault event
		// Switch normal at power-on: no test, failures cleared
		power_cycle(straps_t'(5'b00000), '0);
		act = '0;
		repeat (2000) begin
			@(posedge clk_i);
			#1 act = act | {port_a_tx_o, port_b_tx_o, fault_a_o, fault_b_o, ~&bus_oe_b_o};
		end
		`CHK("idle", 5'b00000, act) // latches cleared
		tally_and_finish();
	end

	initial begin
		repeat (100000) @(posedge clk_i);
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_top
